//--- rtl/sra_pkg.sv
// Purpose: Constants and types for the alignment event logic.
// Assumes: One 20 MHz clock, classic Wishbone register access.
// Notes: Register offsets are byte addresses of 32-bit words.
// Overview of operation
// - Sample the alignment input on every rising clock edge; detect events there.
// - An event is a rising sampled input or a 0-to-1 software bit change.
// - Events come from the pin or a software register bit, selectable.
// - Every event, first included, resets the interleave clock divider.
// - Count events; oscillator phase and multiframe counter reset from the third on.
// - Events align the multiframe boundary and reset filters and timing blocks.
// - Frame and multiframe clocks derive from the device clock and events.
// - A programmable delay sits on the alignment input path for skew.
// - Divider mask blocks events from the clock divider.
// - Oscillator-link mask blocks events from oscillator and link block.
package sra_pkg;
  localparam logic [3:0] SRA_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SRA_ADDR_DELAY = 4'h4;
  localparam logic [3:0] SRA_ADDR_FRAME = 4'h8;
  localparam logic [3:0] SRA_ADDR_STATUS = 4'hc;
  // Control register fields
  localparam int SRA_CTRL_SW_BIT = 0;
  localparam int SRA_CTRL_SRC_SW = 1;
  localparam int SRA_CTRL_DIV_MASK = 2;
  localparam int SRA_CTRL_OSC_MASK = 3;
  localparam int SRA_CTRL_CNT_CLR = 4;
  localparam int SRA_DELAY_W = 4;
  localparam int SRA_DELAY_TAPS = 16;
  localparam int SRA_CNT_W = 8;
  localparam int SRA_DIV_W = 2;
  localparam int SRA_FRAME_W = 4;
  localparam int SRA_MF_W = 5;
  localparam logic [SRA_CNT_W-1:0] SRA_FIRST_LATE_EVENT = 8'h03;
  localparam logic [4:0] SRA_CTRL_RESET = 5'h00;
  localparam logic [SRA_DELAY_W-1:0] SRA_DELAY_RESET = 4'h0;
  localparam logic [SRA_FRAME_W-1:0] SRA_FRAME_LEN_RESET = 4'h3;
  localparam logic [SRA_MF_W-1:0] SRA_MF_LEN_RESET = 5'h0f;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } sra_wb_req_type;

  typedef struct packed {
    logic divider_reset;
    logic oscillator_reset;
    logic multiframe_reset;
    logic filter_reset;
  } sra_resets_type;
endpackage : sra_pkg

//--- rtl/sra_align.sv
// Purpose: Alignment event detection, counting, masking and local clock generation.
// Assumes: Pin input synchronous to clock; Wishbone classic slave, one wait cycle.
// Notes: Unmapped addresses are acked and read as zero; writes there are dropped.
// Notes: The event count saturates at its top value; an event beats a clear in one cycle.
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
module sra_align (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic align_pin,
  input wire logic link_sync_request_input,
  input wire sra_pkg::sra_wb_req_type wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output sra_pkg::sra_resets_type resets,
  output logic local_frame_tick,
  output logic local_multiframe_tick,
  output logic link_sync_active
);
  typedef enum logic [1:0] {SRA_IDLE, SRA_ACK} sra_bus_state_type;

  sra_bus_state_type bus_q, bus_d;
  logic [4:0] ctrl_q, ctrl_d;
  logic [sra_pkg::SRA_DELAY_W-1:0] delay_q, delay_d;
  logic [sra_pkg::SRA_FRAME_W-1:0] frame_len_q, frame_len_d;
  logic [sra_pkg::SRA_MF_W-1:0] mf_len_q, mf_len_d;
  logic [31:0] rdat_q, rdat_d;
  logic [sra_pkg::SRA_DELAY_TAPS-1:0] tap_q;
  logic sampled_q, prev_pin_q, prev_sw_q;
  logic [sra_pkg::SRA_CNT_W-1:0] count_q, count_d;
  sra_pkg::sra_resets_type resets_q, resets_d;
  logic [sra_pkg::SRA_DIV_W-1:0] div_q, div_d;
  logic [sra_pkg::SRA_FRAME_W-1:0] frame_q, frame_d;
  logic [sra_pkg::SRA_MF_W-1:0] mf_q, mf_d;
  logic ftick_q, ftick_d, mtick_q, mtick_d, sync_q;
  logic pin_event, sw_event, align_event, late_event, access, wr_en;

  // Delay line: each tap is one clock of delay on the pin path
  logic [sra_pkg::SRA_DELAY_TAPS-1:0] tap_d;
  genvar t;
  generate
    for (t = 0; t < sra_pkg::SRA_DELAY_TAPS; t = t + 1) begin : g_tap
      if (t == 0) begin : g_head
        assign tap_d[t] = align_pin;
      end else begin : g_link
        assign tap_d[t] = tap_q[t-1];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tap_q <= '0;
    end else begin
      tap_q <= tap_d;
    end
  end

  assign access = wb_req.cyc && wb_req.stb && (bus_q == SRA_IDLE);
  assign wr_en = access && wb_req.we && wb_req.sel[0];

  // Register file decode; one wait state before the ack
  always_comb begin
    bus_d = bus_q;
    ctrl_d = ctrl_q;
    delay_d = delay_q;
    frame_len_d = frame_len_q;
    mf_len_d = mf_len_q;
    rdat_d = rdat_q;
    // Count clear is self clearing
    ctrl_d[sra_pkg::SRA_CTRL_CNT_CLR] = 1'b0;
    case (bus_q)
      SRA_IDLE: begin
        if (access) begin
          bus_d = SRA_ACK;
          rdat_d = 32'h0000_0000;
          case (wb_req.adr)
            sra_pkg::SRA_ADDR_CTRL: begin
              rdat_d[4:0] = ctrl_q;
              if (wr_en) begin
                ctrl_d = wb_req.dat[4:0];
              end
            end
            sra_pkg::SRA_ADDR_DELAY: begin
              rdat_d[sra_pkg::SRA_DELAY_W-1:0] = delay_q;
              if (wr_en) begin
                delay_d = wb_req.dat[sra_pkg::SRA_DELAY_W-1:0];
              end
            end
            sra_pkg::SRA_ADDR_FRAME: begin
              rdat_d[sra_pkg::SRA_FRAME_W-1:0] = frame_len_q;
              rdat_d[8 +: sra_pkg::SRA_MF_W] = mf_len_q;
              if (wr_en) begin
                frame_len_d = wb_req.dat[sra_pkg::SRA_FRAME_W-1:0];
              end
              if (wr_en && wb_req.sel[1]) begin
                mf_len_d = wb_req.dat[8 +: sra_pkg::SRA_MF_W];
              end
            end
            sra_pkg::SRA_ADDR_STATUS: begin
              rdat_d[sra_pkg::SRA_CNT_W-1:0] = count_q;
              rdat_d[8] = sampled_q;
              rdat_d[9] = sync_q;
              rdat_d[10 +: sra_pkg::SRA_DIV_W] = div_q;
            end
            default: begin
              rdat_d = 32'h0000_0000;
            end
          endcase
        end
      end
      SRA_ACK: begin
        bus_d = SRA_IDLE;
      end
      default: begin
        bus_d = SRA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_q <= SRA_IDLE;
      ctrl_q <= sra_pkg::SRA_CTRL_RESET;
      delay_q <= sra_pkg::SRA_DELAY_RESET;
      frame_len_q <= sra_pkg::SRA_FRAME_LEN_RESET;
      mf_len_q <= sra_pkg::SRA_MF_LEN_RESET;
      rdat_q <= 32'h0000_0000;
    end else begin
      bus_q <= bus_d;
      ctrl_q <= ctrl_d;
      delay_q <= delay_d;
      frame_len_q <= frame_len_d;
      mf_len_q <= mf_len_d;
      rdat_q <= rdat_d;
    end
  end

  // Ack comes straight from the state register, so it never glitches
  assign wb_ack_o = (bus_q == SRA_ACK);
  assign wb_dat_o = rdat_q;

  // Tap select and edge history; both histories reset low like an idle pin
  logic sampled_d;
  logic prev_pin_d;
  logic prev_sw_d;
  always_comb begin
    sampled_d = tap_q[delay_q];
    prev_pin_d = sampled_q;
    prev_sw_d = ctrl_q[sra_pkg::SRA_CTRL_SW_BIT];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sampled_q <= 1'b0;
      prev_pin_q <= 1'b0;
      prev_sw_q <= 1'b0;
    end else begin
      sampled_q <= sampled_d;
      prev_pin_q <= prev_pin_d;
      prev_sw_q <= prev_sw_d;
    end
  end

  // Edge detection on the delayed pin and on the software bit
  // Only the selected source can raise an event
  assign pin_event = sampled_q && !prev_pin_q;
  assign sw_event = ctrl_q[sra_pkg::SRA_CTRL_SW_BIT] && !prev_sw_q;
  assign align_event = ctrl_q[sra_pkg::SRA_CTRL_SRC_SW] ? sw_event : pin_event;

  // Counter saturates so a long pulse train never wraps back below three
  logic count_full;
  logic count_clear;
  assign count_full = (count_q == {sra_pkg::SRA_CNT_W{1'b1}});
  assign count_clear = ctrl_q[sra_pkg::SRA_CTRL_CNT_CLR];

  always_comb begin
    count_d = count_q;
    if (align_event) begin
      if (!count_full) begin
        count_d = count_q + 8'h01;
      end
    end else if (count_clear) begin
      count_d = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 8'h00;
    end else begin
      count_q <= count_d;
    end
  end

  // Late events need the count including this event, hence count_d
  assign late_event = align_event && (count_d >= sra_pkg::SRA_FIRST_LATE_EVENT);

  // Filters follow every event; only divider and oscillator-link paths are maskable
  always_comb begin
    resets_d = '0;
    resets_d.divider_reset = align_event && !ctrl_q[sra_pkg::SRA_CTRL_DIV_MASK];
    resets_d.oscillator_reset = late_event && !ctrl_q[sra_pkg::SRA_CTRL_OSC_MASK];
    resets_d.multiframe_reset = late_event && !ctrl_q[sra_pkg::SRA_CTRL_OSC_MASK];
    resets_d.filter_reset = align_event;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resets_q <= '0;
    end else begin
      resets_q <= resets_d;
    end
  end

  // Divider phase restarts on every unmasked event
  always_comb begin
    if (resets_d.divider_reset) begin
      div_d = '0;
    end else begin
      div_d = div_q + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // Frame counter; a multiframe reset restarts it so the boundary lands on the event
  logic frame_wrap;
  assign frame_wrap = (frame_q == frame_len_q);

  always_comb begin
    frame_d = frame_q;
    ftick_d = 1'b0;
    if (resets_d.multiframe_reset) begin
      frame_d = '0;
    end else if (frame_wrap) begin
      frame_d = '0;
      ftick_d = 1'b1;
    end else begin
      frame_d = frame_q + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= '0;
      ftick_q <= 1'b0;
    end else begin
      frame_q <= frame_d;
      ftick_q <= ftick_d;
    end
  end

  // Multiframe counter advances once per frame wrap
  always_comb begin
    mf_d = mf_q;
    mtick_d = 1'b0;
    if (resets_d.multiframe_reset) begin
      mf_d = '0;
    end else if (frame_wrap) begin
      if (mf_q == mf_len_q) begin
        mf_d = '0;
        mtick_d = 1'b1;
      end else begin
        mf_d = mf_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mf_q <= '0;
      mtick_q <= 1'b0;
    end else begin
      mf_q <= mf_d;
      mtick_q <= mtick_d;
    end
  end

  // Link sync request is active low; mirrored one clock late
  logic sync_d;
  always_comb begin
    sync_d = !link_sync_request_input;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign resets = resets_q;
  assign local_frame_tick = ftick_q;
  assign local_multiframe_tick = mtick_q;
  assign link_sync_active = sync_q;
endmodule : sra_align

//--- tb/sra_align_monitor.sv
// Purpose: Port checks for the alignment event logic.
// Assumes: Classic bus master; pin low between events.
// Notes: Tap delay is not visible here, so latency is left to the bench.
`timescale 1ns/1ns
module sra_align_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic link_sync_request_input,
  input wire sra_pkg::sra_wb_req_type wb_req,
  input wire logic wb_ack_o,
  input wire sra_pkg::sra_resets_type resets,
  input wire logic link_sync_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    $rose(wb_req.cyc && wb_req.stb) && !wb_ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_idle: assert property (!wb_req.stb |=> !wb_ack_o)
    else $error("ack without strobe");
  a_div_event: assert property (resets.divider_reset |-> resets.filter_reset)
    else $error("divider pulse without event");
  a_osc_mf_pair: assert property (resets.oscillator_reset == resets.multiframe_reset)
    else $error("oscillator and multiframe pulses differ");
  a_late_event: assert property (resets.oscillator_reset |-> resets.filter_reset)
    else $error("oscillator pulse without event");
  a_one_pulse: assert property (resets.filter_reset |=> !resets.filter_reset)
    else $error("event pulse repeated");
  a_sync_mirror: assert property ($past(rst_b, 2) |->
    link_sync_active == !$past(link_sync_request_input))
    else $error("sync mirror wrong");
endmodule : sra_align_monitor

bind sra_align sra_align_monitor mon (.clock(clock), .rst_b(rst_b), .wb_req(wb_req),
  .link_sync_request_input(link_sync_request_input), .wb_ack_o(wb_ack_o),
  .resets(resets), .link_sync_active(link_sync_active));

//--- tb/sra_sysref_src.sv
// Purpose: Far-side alignment pulse source.
// Assumes: Pulse launched on the edge after fire.
// Notes: Idle low between pulses; three cycles high.
`timescale 1ns/1ns
module sra_sysref_src (
  input wire logic clock,
  input wire logic fire,
  output logic pin
);
  logic [1:0] n_q = 2'h0;
  initial pin = 1'b0;
  // One clean pulse per request; caller spaces requests apart
  always @(posedge clock) begin
    n_q <= fire ? 2'h3 : n_q - 2'(n_q != 2'h0);
    pin <= fire || n_q > 2'h1;
  end
endmodule : sra_sysref_src

//--- tb/test_sysref_alignment_event_logic.sv
// Purpose: Self-checking bench for the alignment event logic.
// Assumes: Seeded random tap delays and sync level.
// Notes: Latency counts edges after the trigger is released.
`timescale 1ns/1ns
module test_sysref_alignment_event_logic;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic fire = 1'b0;
  logic sync_n = 1'b1;
  logic pin, ack, ftk, mtk, act;
  logic [31:0] rd, q;
  sra_pkg::sra_wb_req_type req = '0;
  sra_pkg::sra_resets_type rs, g;
  int fail_count = 0;
  int checks_done = 0;
  int lat, d, fg, mg;
  always #25 clock = ~clock;
  sra_sysref_src src (.clock(clock), .fire(fire), .pin(pin));
  sra_align uut (.clock(clock), .rst_b(rst_b), .align_pin(pin), .link_sync_request_input(sync_n),
    .wb_req(req), .wb_dat_o(rd), .wb_ack_o(ack), .resets(rs), .local_frame_tick(ftk),
    .local_multiframe_tick(mtk), .link_sync_active(act));
  always @(posedge clock) if (rst_b) sync_n <= 1'($urandom);
  function automatic logic late(int n);
    return n >= 3;
  endfunction : late
  function automatic int frame_edges();
    return int'(sra_pkg::SRA_FRAME_LEN_RESET) + 1;
  endfunction : frame_edges
  function automatic int mf_frames();
    return int'(sra_pkg::SRA_MF_LEN_RESET) + 1;
  endfunction : mf_frames
  // Edges from a multiframe reset to the first frame tick and multiframe tick
  task automatic ticks(output int f, output int m);
    f = 0;
    m = 0;
    for (int i = 1; i <= 200 && m == 0; i++) begin
      @(posedge clock);
      #1;
      if (ftk === 1'b1 && f == 0) f = i;
      if (mtk === 1'b1) m = i;
    end
  endtask : ticks
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(logic w, logic [3:0] a, logic [31:0] dat);
    @(posedge clock);
    req <= '{1'b1, 1'b1, w, 4'hf, a, dat};
    do @(posedge clock); while (ack !== 1'b1);
    q = rd;
    req <= '0;
  endtask : wb
  // Pin pulse when p is set, otherwise a control write; then watch for the event
  task automatic ev(logic p, logic [31:0] cw);
    g = '0;
    lat = 0;
    // Let an earlier pulse drain out of the delay line first
    repeat (sra_pkg::SRA_DELAY_TAPS + 4) @(posedge clock);
    if (p) begin
      @(posedge clock);
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
    end else begin
      wb(1'b1, sra_pkg::SRA_ADDR_CTRL, cw);
      // A software event pulses at the edge that returns the ack
      #1;
      if (rs.filter_reset === 1'b1) begin
        g = rs;
        lat = 1;
      end
    end
    for (int i = 1; i < 40 && lat == 0; i++) begin
      @(posedge clock);
      #1;
      if (rs.filter_reset === 1'b1) begin
        g = rs;
        lat = i;
      end
    end
  endtask : ev
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    void'($urandom(32'h87a04781));
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    for (int n = 1; n <= 5; n++) begin
      ev(1'b1, '0);
      chk(g.divider_reset, 1'b1);
      chk(g.oscillator_reset, late(n));
      chk(g.multiframe_reset, late(n));
      chk(lat, 3);
      if (late(n)) begin
        ticks(fg, mg);
        chk(fg, frame_edges());
        chk(mg, frame_edges() * mf_frames());
      end
    end
    wb(1'b0, sra_pkg::SRA_ADDR_STATUS, '0);
    chk(q[7:0], 8'h05);
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 15 : $urandom % 16;
      wb(1'b1, sra_pkg::SRA_ADDR_DELAY, d);
      ev(1'b1, '0);
      chk(lat, d + 3);
    end
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, sra_pkg::SRA_ADDR_CTRL, 32'h4 << m);
      ev(1'b1, '0);
      chk(g.divider_reset, m);
      chk(g.oscillator_reset, !m);
    end
    wb(1'b1, sra_pkg::SRA_ADDR_CTRL, 32'h2);
    ev(1'b1, '0);
    chk(lat, 0);
    ev(1'b0, 32'h3);
    chk(g.divider_reset, 1'b1);
    chk(lat, 1);
    ev(1'b0, 32'h3);
    chk(lat, 0);
    wb(1'b1, sra_pkg::SRA_ADDR_CTRL, 32'h2);
    ev(1'b0, 32'h3);
    chk(g.divider_reset, 1'b1);
    wb(1'b1, sra_pkg::SRA_ADDR_CTRL, 32'h10);
    wb(1'b0, sra_pkg::SRA_ADDR_STATUS, '0);
    chk(q[7:0], 8'h00);
    wb(1'b0, 4'h2, '0);
    chk(q, 32'h0);
    test_done;
  end
  initial begin
    #1000000;
    fail_count++;
    test_done;
  end
endmodule : test_sysref_alignment_event_logic
